// File: include/sph_pkg.sv
/*
 * Shared types and constants for the semaphore port controller: command
 * codes, pin and user-side bundles, and access timing.
 * Assumes a 250 MHz system clock and one port of a dual-port RAM with
 * eight semaphore latches selected by an active-low semaphore select.
 */
package sph_pkg;

    // Port widths of the RAM side.
    localparam int ADDR_W    = 15;
    localparam int DATA_W    = 8;
    localparam int SEM_IDX_W = 3;
    localparam int SEM_COUNT = 8;

    // Clock period and access timing; the times are plain defaults.
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_WRITE_NS    = 20;
    localparam int T_READ_NS     = 20;
    localparam int T_GAP_NS      = 8;

    // Least times round up to whole cycles.
    localparam int WRITE_CYC = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC  = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC   = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W     = 4;

    // Flag levels: a held token is low.
    localparam logic FLAG_TAKE = 1'h0;
    localparam logic FLAG_FREE = 1'h1;

    // User commands.
    typedef enum logic [1:0] {
        SPH_CMD_CLAIM   = 2'h0,
        SPH_CMD_RELEASE = 2'h1,
        SPH_CMD_POLL    = 2'h2,
        SPH_CMD_INIT    = 2'h3
    } sph_cmd_t;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        SPH_S_IDLE  = 4'h1,
        SPH_S_WRITE = 4'h2,
        SPH_S_READ  = 4'h4,
        SPH_S_GAP   = 4'h8
    } sph_state_t;

    // Request from the user side.
    typedef struct packed {
        sph_cmd_t               cmd;
        logic [SEM_IDX_W-1:0]   index;
        logic                   withdraw;
    } sph_req_t;

    // Answer to the user side.
    typedef struct packed {
        sph_cmd_t               cmd;
        logic [SEM_IDX_W-1:0]   index;
        logic                   flag;
        logic                   owned;
    } sph_resp_t;

    // Pins driven toward the RAM port.
    typedef struct packed {
        logic                   ce_n;
        logic                   semaphore_select_n;
        logic                   oe_n;
        logic                   rw_n;
        logic [ADDR_W-1:0]      addr;
        logic [DATA_W-1:0]      dq_out;
        logic                   dq_oe_n;
    } sph_pins_t;

    // Idle values of the pin bundle between accesses: everything idle, bus released.
    localparam sph_pins_t PINS_IDLE = '{
        ce_n: 1'h1, semaphore_select_n: 1'h1, oe_n: 1'h1, rw_n: 1'h1,
        addr: 15'h0000, dq_out: 8'hFF, dq_oe_n: 1'h1
    };

endpackage : sph_pkg

// File: hw/sph_port_ctrl.sv
/*
 * Semaphore port controller: drives one port of a dual-port RAM's
 * semaphore space on behalf of a local user, with claim, release, poll
 * and initialise commands.
 * Assumes the RAM pins are synchronous to clk and that the far port is
 * driven by an independent party; the RAM array itself is never touched.
 */
// Summary of operation
// - Write zero claims, write one releases
// - Select low, strobes used like RAM
// - Deassert select or enable between reads
// - Claim by write first, then read
// - After failure re-read or write one
// - Software writes one to all eight
// - Hold chip enable high for semaphores
`timescale 1ns/10ps
`default_nettype none

module sph_port_ctrl
    import sph_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       reset,
    // User request side.
    input  wire logic       req_valid,
    input  wire sph_req_t   req,
    output var  logic       req_ready,
    // User answer side.
    output var  logic       resp_valid,
    output var  sph_resp_t  resp,
    // RAM port pins.
    output var  sph_pins_t  pins,
    input  wire logic [DATA_W-1:0] dq_in
);

    sph_state_t             state_reg;
    sph_state_t             state_next;
    sph_state_t             after_gap_reg;
    sph_state_t             after_gap_next;
    logic [CNT_W-1:0]       cnt_reg;
    logic [CNT_W-1:0]       cnt_next;
    sph_cmd_t               cmd_reg;
    sph_cmd_t               cmd_next;
    logic [SEM_IDX_W-1:0]   idx_reg;
    logic [SEM_IDX_W-1:0]   idx_next;
    logic                   withdraw_reg;
    logic                   withdraw_next;
    logic                   wr_val_reg;
    logic                   wr_val_next;
    logic                   done_reg;
    logic                   done_next;
    sph_pins_t              pins_reg;
    sph_pins_t              pins_next;
    logic                   ready_reg;
    logic                   ready_next;
    logic                   resp_valid_reg;
    logic                   resp_valid_next;
    sph_resp_t              resp_reg;
    sph_resp_t              resp_next;

    // Pin pattern for a semaphore write of one bit.
    function automatic sph_pins_t write_pins(logic [SEM_IDX_W-1:0] idx, logic val);
        sph_pins_t p;
        p                    = PINS_IDLE;
        p.ce_n               = 1'h1;
        p.semaphore_select_n = 1'h0;
        p.rw_n               = 1'h0;
        p.addr               = {{(ADDR_W-SEM_IDX_W){1'b0}}, idx};
        p.dq_out             = {DATA_W{val}};
        p.dq_oe_n            = 1'h0;
        return p;
    endfunction : write_pins

    // Pin pattern for a semaphore read; our data drivers stay off.
    function automatic sph_pins_t read_pins(logic [SEM_IDX_W-1:0] idx);
        sph_pins_t p;
        p                    = PINS_IDLE;
        p.ce_n               = 1'h1;
        p.semaphore_select_n = 1'h0;
        p.oe_n               = 1'h0;
        p.addr               = {{(ADDR_W-SEM_IDX_W){1'b0}}, idx};
        return p;
    endfunction : read_pins

    // Sequencer next state. Every access ends in a gap with select and
    // enable high, so a repeated poll always opens a fresh read latch.
    always_comb
    begin
        state_next      = state_reg;
        after_gap_next  = after_gap_reg;
        cnt_next        = cnt_reg;
        cmd_next        = cmd_reg;
        idx_next        = idx_reg;
        withdraw_next   = withdraw_reg;
        wr_val_next     = wr_val_reg;
        done_next       = done_reg;
        pins_next       = pins_reg;
        ready_next      = 1'b0;
        resp_valid_next = 1'b0;
        resp_next       = resp_reg;
        unique case (state_reg)
            SPH_S_IDLE:
            begin
                ready_next = 1'b1;
                if (req_valid && ready_reg)
                begin
                    ready_next    = 1'b0;
                    cmd_next      = req.cmd;
                    idx_next      = req.cmd == SPH_CMD_INIT ? '0 : req.index;
                    withdraw_next = req.withdraw;
                    done_next     = 1'b0;
                    cnt_next      = CNT_W'(1);
                    if (req.cmd == SPH_CMD_POLL)
                    begin
                        state_next = SPH_S_READ;
                        pins_next  = read_pins(req.index);
                    end
                    else
                    begin
                        // A claim is always write first, then read back.
                        wr_val_next = req.cmd == SPH_CMD_CLAIM ? FLAG_TAKE : FLAG_FREE;
                        state_next  = SPH_S_WRITE;
                        pins_next   = write_pins(req.cmd == SPH_CMD_INIT ? '0 : req.index,
                                                 req.cmd == SPH_CMD_CLAIM ? FLAG_TAKE
                                                                          : FLAG_FREE);
                    end
                end
            end
            SPH_S_WRITE:
            begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (cnt_reg == CNT_W'(WRITE_CYC))
                begin
                    cnt_next  = CNT_W'(1);
                    pins_next = PINS_IDLE;
                    state_next = SPH_S_GAP;
                    // Only a fresh claim goes on to the read-back.
                    if (cmd_reg == SPH_CMD_CLAIM && wr_val_reg == FLAG_TAKE)
                        after_gap_next = SPH_S_READ;
                    else
                        after_gap_next = SPH_S_IDLE;
                end
            end
            SPH_S_READ:
            begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (cnt_reg == CNT_W'(READ_CYC))
                begin
                    cnt_next       = CNT_W'(1);
                    pins_next      = PINS_IDLE;
                    state_next     = SPH_S_GAP;
                    after_gap_next = SPH_S_IDLE;
                    resp_next.cmd   = cmd_reg;
                    resp_next.index = idx_reg;
                    resp_next.flag  = dq_in[0];
                    resp_next.owned = dq_in[0] == FLAG_TAKE;
                    // A lost claim leaves our request pending; withdraw it
                    // when asked, else the user must keep polling.
                    if (cmd_reg == SPH_CMD_CLAIM && dq_in[0] == FLAG_FREE && withdraw_reg)
                    begin
                        wr_val_next    = FLAG_FREE;
                        after_gap_next = SPH_S_WRITE;
                    end
                    else
                        done_next = 1'b1;
                end
            end
            SPH_S_GAP:
            begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (cnt_reg == CNT_W'(GAP_CYC))
                begin
                    cnt_next = CNT_W'(1);
                    if (after_gap_reg == SPH_S_READ)
                    begin
                        state_next = SPH_S_READ;
                        pins_next  = read_pins(idx_reg);
                    end
                    else if (after_gap_reg == SPH_S_WRITE)
                    begin
                        state_next = SPH_S_WRITE;
                        pins_next  = write_pins(idx_reg, wr_val_reg);
                    end
                    else if (cmd_reg == SPH_CMD_INIT && idx_reg != SEM_IDX_W'(SEM_COUNT - 1))
                    begin
                        // Free every latch in turn so none starts held.
                        idx_next   = idx_reg + SEM_IDX_W'(1);
                        state_next = SPH_S_WRITE;
                        pins_next  = write_pins(idx_reg + SEM_IDX_W'(1), FLAG_FREE);
                    end
                    else
                    begin
                        state_next      = SPH_S_IDLE;
                        ready_next      = 1'b1;
                        resp_valid_next = 1'b1;
                        if (!done_reg)
                        begin
                            resp_next.cmd   = cmd_reg;
                            resp_next.index = idx_reg;
                            resp_next.flag  = wr_val_reg;
                            resp_next.owned = 1'b0;
                        end
                    end
                end
            end
            default:
            begin
                state_next = SPH_S_IDLE;
                pins_next  = PINS_IDLE;
            end
        endcase
    end

    // State registers. After reset the port frees all eight latches itself,
    // since the device has no power-up clearing of its own.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg      <= SPH_S_WRITE;
            after_gap_reg  <= SPH_S_IDLE;
            cnt_reg        <= CNT_W'(1);
            cmd_reg        <= SPH_CMD_INIT;
            idx_reg        <= '0;
            withdraw_reg   <= 1'b0;
            wr_val_reg     <= FLAG_FREE;
            done_reg       <= 1'b0;
            pins_reg       <= write_pins('0, FLAG_FREE);
            ready_reg      <= 1'b0;
            resp_valid_reg <= 1'b0;
            resp_reg       <= '0;
        end
        else
        begin
            state_reg      <= state_next;
            after_gap_reg  <= after_gap_next;
            cnt_reg        <= cnt_next;
            cmd_reg        <= cmd_next;
            idx_reg        <= idx_next;
            withdraw_reg   <= withdraw_next;
            wr_val_reg     <= wr_val_next;
            done_reg       <= done_next;
            pins_reg       <= pins_next;
            ready_reg      <= ready_next;
            resp_valid_reg <= resp_valid_next;
            resp_reg       <= resp_next;
        end
    end

    // Outputs come straight from the registers.
    assign pins       = pins_reg;
    assign req_ready  = ready_reg;
    assign resp_valid = resp_valid_reg;
    assign resp       = resp_reg;

endmodule : sph_port_ctrl

`default_nettype wire

// File: verif/sph_port_ctrl_props.sv
/* Checker for the semaphore port controller: pin phases and answers.
   Assumes the package timing (write 5, read 5, gap 2 cycles). */
`timescale 1ns/10ps
`default_nettype none
module sph_port_ctrl_props
    import sph_pkg::*;
(
    // Clock and reset.
    input wire logic              clk,
    input wire logic              reset,
    // User side.
    input wire logic              req_valid,
    input wire sph_req_t          req,
    input wire logic              req_ready,
    input wire logic              resp_valid,
    input wire sph_resp_t         resp,
    // RAM port side.
    input wire sph_pins_t         pins,
    input wire logic [DATA_W-1:0] dq_in
);
    // One clock domain, so clock and reset are given once.
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    ce_high_a: assert property (pins.ce_n)
        else $error("chip enable driven low");
    addr_stable_a: assert property (!pins.semaphore_select_n && $past(!pins.semaphore_select_n)
        |-> $stable(pins.addr[SEM_IDX_W-1:0]))
        else $error("address moved inside an access");
    write_form_a: assert property (!pins.semaphore_select_n && !pins.rw_n
        |-> !pins.dq_oe_n && pins.oe_n && pins.dq_out == {DATA_W{pins.dq_out[0]}})
        else $error("bad write phase");
    read_form_a: assert property (!pins.oe_n
        |-> pins.dq_oe_n && !pins.semaphore_select_n && pins.rw_n)
        else $error("bad read phase");
    read_len_a: assert property ($fell(pins.oe_n)
        |-> (!pins.oe_n)[*5] ##1 (pins.oe_n && pins.semaphore_select_n)[*2])
        else $error("read phase length or gap wrong");
    write_len_a: assert property ($fell(pins.rw_n)
        |-> (!pins.rw_n)[*5] ##1 (pins.rw_n && pins.semaphore_select_n)[*2])
        else $error("write phase length or gap wrong");
    claim_first_a: assert property (req_valid && req_ready && req.cmd == SPH_CMD_CLAIM
        |=> !pins.rw_n && pins.dq_out[0] == FLAG_TAKE ##7 !pins.oe_n)
        else $error("claim not write then read");
    release_resp_a: assert property (req_valid && req_ready && req.cmd == SPH_CMD_RELEASE
        |-> ##[1:12] (resp_valid && resp.flag == FLAG_FREE && !resp.owned))
        else $error("release answer missing");
    owned_flag_a: assert property (resp_valid && resp.cmd != SPH_CMD_RELEASE
        && resp.cmd != SPH_CMD_INIT |-> resp.owned == !resp.flag)
        else $error("owned disagrees with flag");
    read_value_a: assert property ($rose(pins.oe_n) ##2 resp_valid
        |-> resp.flag == $past(dq_in[0], 3))
        else $error("answer differs from bus value");
endmodule : sph_port_ctrl_props
`default_nettype wire

// File: verif/sph_sem_model.sv
/* Behavioural model of the eight shared semaphore latches, left port on the
   controller's pins, right port on plain signals. Evaluated on clk edges. */
`timescale 1ns/10ps
`default_nettype none
module sph_sem_model
    import sph_pkg::*;
(
    // Clock and left port.
    input wire logic              clk,
    input wire sph_pins_t         pins,
    output var logic [DATA_W-1:0] dq_left,
    // Right port.
    input wire logic              r_sel_n,
    input wire logic              r_oe_n,
    input wire logic              r_rw_n,
    input wire logic [ADDR_W-1:0] r_addr,
    input wire logic [DATA_W-1:0] r_d,
    output var logic [DATA_W-1:0] r_q
);
    // Latches start requested, so an uninitialised run misbehaves.
    logic [SEM_COUNT-1:0] req_l = '0, req_r = '0, own_l = '0, own_r = '0;
    logic [SEM_COUNT-1:0] nl, nr, ol, orr;
    logic                 act_l, act_r, act_lq = 1'b0, act_rq = 1'b0, lat_l = 1'b1, lat_r = 1'b1;
    assign act_l = !pins.semaphore_select_n && !pins.oe_n;
    assign act_r = !r_sel_n && !r_oe_n;

    // Request latches take bit 0 only; a release hands over to a waiter.
    always @(posedge clk)
    begin
        nl = req_l;
        nr = req_r;
        ol = own_l;
        orr = own_r;
        if (pins.ce_n && !pins.semaphore_select_n && !pins.rw_n)
            nl[pins.addr[SEM_IDX_W-1:0]] = pins.dq_out[0];
        if (!r_sel_n && !r_rw_n)
            nr[r_addr[SEM_IDX_W-1:0]] = r_d[0];
        for (int i = 0; i < SEM_COUNT; i++)
        begin
            if (ol[i] && nl[i]) ol[i] = 1'b0;
            if (orr[i] && nr[i]) orr[i] = 1'b0;
            if (!ol[i] && !orr[i])
            begin
                // A waiting right request wins; ties also fall right.
                if (!nr[i]) orr[i] = 1'b1;
                else if (!nl[i]) ol[i] = 1'b1;
            end
        end
        req_l <= nl;
        req_r <= nr;
        own_l <= ol;
        own_r <= orr;
        act_lq <= act_l;
        act_rq <= act_r;
        if (act_l && !act_lq) lat_l <= !own_l[pins.addr[SEM_IDX_W-1:0]];
        if (act_r && !act_rq) lat_r <= !own_r[r_addr[SEM_IDX_W-1:0]];
    end

    // Flag spread over all bits; an idle bus shows the inverse, never a hold.
    assign dq_left = act_lq ? {DATA_W{lat_l}} : {DATA_W{!lat_l}};
    assign r_q     = act_rq ? {DATA_W{lat_r}} : {DATA_W{!lat_r}};
endmodule : sph_sem_model
`default_nettype wire

// File: verif/sph_port_ctrl_bench.sv
/* Self-checking bench: controller on the left port, bench as right port.
   Assumes the semaphore model and the package timing. */
`timescale 1ns/10ps
`default_nettype none
module sph_port_ctrl_bench
    import sph_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_ready, resp_valid;
    logic r_sel_n = 1'b1, r_oe_n = 1'b1, r_rw_n = 1'b1;
    logic [ADDR_W-1:0] r_addr = '0;
    logic [DATA_W-1:0] r_d = 8'hFF, r_q, dq_in;
    sph_req_t  req = '0;
    sph_resp_t resp;
    sph_pins_t pins;
    int n_fail = 0, total_checks = 0;

    sph_port_ctrl i_sph_port_ctrl (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .pins(pins), .dq_in(dq_in));
    sph_sem_model i_sph_sem_model (.clk(clk), .pins(pins), .dq_left(dq_in), .r_sel_n(r_sel_n),
        .r_oe_n(r_oe_n), .r_rw_n(r_rw_n), .r_addr(r_addr), .r_d(r_d), .r_q(r_q));

    // 250 MHz clock.
    initial forever #2 clk = !clk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // Compare of data read on the right port.
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: data got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Compare of a whole answer word from the controller.
    task automatic chk_resp(input sph_resp_t got, input sph_resp_t exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: answer got %h expected %h", $time, got, exp);
        end
    endtask : chk_resp

    // Waits are bounded so a dead handshake ends as a mismatch. The flag is
    // picked by value, since not every simulator takes a port net by reference.
    task automatic wait_hi(input bit on_resp);
        int k;
        k = 0;
        while ((on_resp ? resp_valid : req_ready) !== 1'b1 && k < 100)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 100)
        begin
            n_fail++;
            $display("MISMATCH at %0t: handshake timed out", $time);
        end
    endtask : wait_hi

    // One request; owned is expected only for a read flag of zero.
    task automatic op(input sph_cmd_t c, input logic [2:0] i, input logic w, input logic f);
        sph_resp_t exp;
        exp = '{cmd: c, index: i, flag: f, owned: 1'b0};
        exp.owned = (c == SPH_CMD_CLAIM || c == SPH_CMD_POLL) && !f;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req = '{cmd: c, index: i, withdraw: w};
        wait_hi(1'b0);
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        wait_hi(1'b1);
        chk_resp(resp, exp);
    endtask : op

    // Right port write; high address and data bits carry junk.
    task automatic r_wr(input logic [2:0] i, input logic v);
        @(posedge clk);
        #1;
        r_sel_n = 1'b0;
        r_rw_n = 1'b0;
        r_addr = {12'hFFF, i};
        r_d = {7'h5A, v};
        repeat (2) @(posedge clk);
        #1;
        r_sel_n = 1'b1;
        r_rw_n = 1'b1;
    endtask : r_wr

    // Right port read, then select is dropped so the next read relatches.
    task automatic r_rd(input logic [2:0] i, input logic v);
        @(posedge clk);
        #1;
        r_sel_n = 1'b0;
        r_oe_n = 1'b0;
        r_addr = {12'hABC, i};
        repeat (2) @(posedge clk);
        #1;
        chk(r_q, {DATA_W{v}});
        r_sel_n = 1'b1;
        r_oe_n = 1'b1;
    endtask : r_rd

    // Watchdog well past the expected few hundred cycles.
    initial
    begin
        #60000;
        n_fail++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // After reset the controller frees all eight latches on its own.
    task automatic test_init;
        wait_hi(1'b1);
        chk_resp(resp, sph_resp_t'{cmd: SPH_CMD_INIT, index: 3'h7, flag: 1'b1, owned: 1'b0});
        for (int i = 0; i < 8; i++) r_wr(i[2:0], 1'b1);
        for (int i = 0; i < 8; i++) op(SPH_CMD_POLL, i[2:0], 1'b0, 1'b1);
        $display("test init done");
    endtask : test_init

    // A held token is passed to a waiting right request on release.
    task automatic test_handover;
        op(SPH_CMD_CLAIM, 3'h3, 1'b0, 1'b0);
        r_rd(3'h3, 1'b1);
        r_wr(3'h3, 1'b0);
        r_rd(3'h3, 1'b1);
        op(SPH_CMD_POLL, 3'h3, 1'b0, 1'b0);
        op(SPH_CMD_RELEASE, 3'h3, 1'b0, 1'b1);
        r_rd(3'h3, 1'b0);
        op(SPH_CMD_POLL, 3'h3, 1'b0, 1'b1);
        r_wr(3'h3, 1'b1);
        op(SPH_CMD_POLL, 3'h3, 1'b0, 1'b1);
        $display("test handover done");
    endtask : test_handover

    // A lost claim with withdraw leaves no request behind.
    task automatic test_withdraw;
        r_wr(3'h5, 1'b0);
        op(SPH_CMD_CLAIM, 3'h5, 1'b1, 1'b1);
        r_wr(3'h5, 1'b1);
        r_rd(3'h5, 1'b1);
        op(SPH_CMD_POLL, 3'h5, 1'b0, 1'b1);
        $display("test withdraw done");
    endtask : test_withdraw

    // A lost claim without withdraw wins once the right side lets go.
    task automatic test_pending;
        r_wr(3'h6, 1'b0);
        op(SPH_CMD_CLAIM, 3'h6, 1'b0, 1'b1);
        r_wr(3'h6, 1'b1);
        r_rd(3'h6, 1'b1);
        op(SPH_CMD_POLL, 3'h6, 1'b0, 1'b0);
        op(SPH_CMD_RELEASE, 3'h6, 1'b0, 1'b1);
        $display("test pending done");
    endtask : test_pending

    // Every index claims and releases apart from its neighbour.
    task automatic test_all_index;
        for (int i = 0; i < 8; i++)
        begin
            op(SPH_CMD_CLAIM, i[2:0], 1'b0, 1'b0);
            r_rd(i[2:0], 1'b1);
            r_rd(i[2:0] + 3'h1, 1'b1);
            op(SPH_CMD_RELEASE, i[2:0], 1'b0, 1'b1);
        end
        $display("test all_index done");
    endtask : test_all_index

    // A user init must free a held latch and withdraw a pending request.
    task automatic test_user_init;
        op(SPH_CMD_CLAIM, 3'h2, 1'b0, 1'b0);
        r_wr(3'h4, 1'b0);
        op(SPH_CMD_CLAIM, 3'h4, 1'b0, 1'b1);
        op(SPH_CMD_INIT, 3'h7, 1'b0, 1'b1);
        r_wr(3'h2, 1'b0);
        r_rd(3'h2, 1'b0);
        r_wr(3'h4, 1'b1);
        op(SPH_CMD_POLL, 3'h4, 1'b0, 1'b1);
        r_wr(3'h2, 1'b1);
        $display("test user_init done");
    endtask : test_user_init

    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        reset = 1'b0;
        test_init();
        test_handover();
        test_withdraw();
        test_pending();
        test_all_index();
        test_user_init();
        report_and_stop();
    end
endmodule : sph_port_ctrl_bench

bind sph_port_ctrl sph_port_ctrl_props i_sph_port_ctrl_props (.clk(clk), .reset(reset),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp(resp), .pins(pins), .dq_in(dq_in));
`default_nettype wire
